// *** nco_pkg.sv ***
// constants shared by the oscillator register block and its helpers
// assumes one 40 MHz clock and a byte-wide register port
package nco_pkg;

	localparam int unsigned ADDR_W      = 3;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned PHASE_W     = 20;
	localparam int unsigned UPPER_W     = 4;
	localparam int unsigned SYNC_STAGES = 3;

	// register offsets on the byte port
	localparam logic [ADDR_W-1:0] OFS_ACCUM_LOW  = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_ACCUM_HIGH = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_ACCUM_UPR  = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_STEP_LOW   = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_STEP_HIGH  = 3'h4;
	localparam logic [ADDR_W-1:0] OFS_STEP_UPR   = 3'h5;
	localparam logic [ADDR_W-1:0] OFS_CTRL       = 3'h6;

	// field positions
	localparam int unsigned LOW_LSB        = 0;
	localparam int unsigned HIGH_LSB       = 8;
	localparam int unsigned UPPER_LSB      = 16;
	localparam int unsigned CTRL_ENABLE    = 0;
	localparam int unsigned CTRL_PENDING   = 1;

	// reset values
	localparam logic [PHASE_W-1:0] ACCUM_RESET = 20'h00000;
	localparam logic [PHASE_W-1:0] STEP_RESET  = 20'h00001;
	localparam logic               ENABLE_RESET = 1'b0;
	localparam logic [DATA_W-1:0]  RDATA_IDLE   = 8'h00;

	// one byte lane of a 20-bit value; upper lane pads bits 7:4 with zero
	function automatic logic [DATA_W-1:0] lane_of(input logic [PHASE_W-1:0] v, input logic [1:0] idx);
		logic [DATA_W-1:0] r;
		r = RDATA_IDLE;
		if (idx == 2'h0) begin
			r = v[LOW_LSB +: DATA_W];
		end else if (idx == 2'h1) begin
			r = v[HIGH_LSB +: DATA_W];
		end else begin
			r = {4'h0, v[UPPER_LSB +: UPPER_W]};
		end
		return r;
	endfunction : lane_of

endpackage : nco_pkg

// *** nco_link_if.sv ***
// edge, step and shadow signals passed among the oscillator modules
// assumes all three modules share clock_in
`timescale 1ns/1ps
`default_nettype none
interface nco_link_if;
	import nco_pkg::*;
	logic               rise;
	logic               fall;
	logic               low_write;
	logic [PHASE_W-1:0] step_value;
	logic [PHASE_W-1:0] shadow;
	logic               pending;

	modport edge_mp (output rise, output fall);
	modport shadow_mp (input fall, input low_write, input step_value, output shadow, output pending);
	modport main_mp (input rise, input fall, input shadow, input pending, output low_write, output step_value);
endinterface : nco_link_if
`default_nettype wire

// *** osc_edge_sync.sv ***
// three-stage synchroniser and edge detector for the oscillator input clock
// assumes the input clock is well below half of clock_in
`timescale 1ns/1ps
`default_nettype none
module osc_edge_sync
	import nco_pkg::*;
(
	input  wire logic clock_in,
	input  wire logic rst_in,
	input  wire logic osc_clk_in,
	nco_link_if.edge_mp link
);
	logic [SYNC_STAGES-1:0] sync_q;
	logic                   level_q;
	logic                   agree;

	// stage 0 feeds stage 1 only
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			sync_q <= '0;
		end else begin
			sync_q <= {sync_q[SYNC_STAGES-2:0], osc_clk_in};
		end
	end

	assign agree = (sync_q[1] == sync_q[2]);

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			level_q <= 1'b0;
		end else if (agree) begin
			level_q <= sync_q[2];
		end
	end

	assign link.rise = agree && sync_q[2] && !level_q;
	assign link.fall = agree && !sync_q[2] && level_q;

	AST_EDGE_ONEHOT: assert property (@(posedge clock_in) disable iff (rst_in)
		!(link.rise && link.fall)) else $error("rise and fall together");
endmodule : osc_edge_sync
`default_nettype wire

// *** phase_step_shadow.sv ***
// double buffer between the software step value and the accumulator
// assumes low_write is a one-cycle pulse per low-byte write
`timescale 1ns/1ps
`default_nettype none
module phase_step_shadow
	import nco_pkg::*;
(
	input  wire logic clock_in,
	input  wire logic rst_in,
	nco_link_if.shadow_mp link
);
	logic [PHASE_W-1:0] shadow_q;
	logic               pending_q;
	logic               load;

	assign load = link.fall && pending_q;

	// a write in the load cycle re-arms, so the newest value is not lost
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			pending_q <= 1'b0;
		end else begin
			pending_q <= link.low_write || (pending_q && !link.fall);
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			shadow_q <= STEP_RESET;
		end else if (load) begin
			shadow_q <= link.step_value;
		end
	end

	assign link.shadow  = shadow_q;
	assign link.pending = pending_q;

	AST_SHADOW_LOAD: assert property (@(posedge clock_in) disable iff (rst_in)
		(link.fall && pending_q) |=> (shadow_q == $past(link.step_value))) else $error("shadow missed load");
	AST_SHADOW_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
		!(link.fall && pending_q) |=> $stable(shadow_q)) else $error("shadow changed without load");
	AST_PENDING_SET: assert property (@(posedge clock_in) disable iff (rst_in)
		link.low_write |=> pending_q) else $error("low write did not arm shadow");
endmodule : phase_step_shadow
`default_nettype wire

// *** nco_phase_accumulator_regs.sv ***
// register block of the numerically controlled oscillator: phase accumulator and step
// assumes a byte register port on clock_in and an oscillator input clock from a pin
`timescale 1ns/1ps
`default_nettype none
// Function
// - accumulator bits 7:0 form a read/write byte, zero after reset.
// - accumulator bits 15:8 form a read/write byte, zero after reset.
// - accumulator bits 19:16 sit in upper byte bits 3:0; bits 7:4 read zero.
// - upper, high and low accumulator bytes form one 24-bit space, 20 bits used.
// - accumulator advances from the oscillator input clock, not the register port.
// - no atomic multi-byte access; bytes are read and written independently.
// - step bits 7:0 form a read/write byte, resetting to 0x01.
// - step bits 15:8 form a read/write byte, zero after reset.
// - step bits 19:16 sit in upper step byte bits 3:0; bits 7:4 read zero.
// - shadow takes all step bytes at the first input falling edge after low write.
module nco_phase_accumulator_regs
	import nco_pkg::*;
(
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	input  wire logic              osc_clk_in,
	output var  logic [DATA_W-1:0] rdata_out,
	output var  logic [PHASE_W-1:0] phase_accum_out,
	output var  logic [PHASE_W-1:0] phase_step_shadow_out,
	output var  logic              accum_wrap_out,
	output var  logic              osc_enable_out
);

	nco_link_if link ();

	logic [PHASE_W-1:0] accum_q;
	logic [PHASE_W-1:0] accum_d;
	logic [PHASE_W-1:0] step_q;
	logic               enable_q;
	logic [DATA_W-1:0]  rdata_q;
	logic [DATA_W-1:0]  rdata_d;
	logic               wrap_q;
	logic [PHASE_W:0]   sum;
	logic               wr_accum_low;
	logic               wr_accum_high;
	logic               wr_accum_upr;
	logic               wr_accum_any;
	logic               wr_step_low;
	logic               wr_step_high;
	logic               wr_step_upr;
	logic               wr_ctrl;
	logic               advance;

	osc_edge_sync u_edge (
		.clock_in   (clock_in),
		.rst_in     (rst_in),
		.osc_clk_in (osc_clk_in),
		.link       (link)
	);

	phase_step_shadow u_shadow (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.link     (link)
	);

	// write decode
	always_comb begin
		wr_accum_low  = 1'b0;
		wr_accum_high = 1'b0;
		wr_accum_upr  = 1'b0;
		wr_step_low   = 1'b0;
		wr_step_high  = 1'b0;
		wr_step_upr   = 1'b0;
		wr_ctrl       = 1'b0;
		if (!wr_in) begin
			wr_ctrl = 1'b0;
		end else if (addr_in == OFS_ACCUM_LOW) begin
			wr_accum_low = 1'b1;
		end else if (addr_in == OFS_ACCUM_HIGH) begin
			wr_accum_high = 1'b1;
		end else if (addr_in == OFS_ACCUM_UPR) begin
			wr_accum_upr = 1'b1;
		end else if (addr_in == OFS_STEP_LOW) begin
			wr_step_low = 1'b1;
		end else if (addr_in == OFS_STEP_HIGH) begin
			wr_step_high = 1'b1;
		end else if (addr_in == OFS_STEP_UPR) begin
			wr_step_upr = 1'b1;
		end else if (addr_in == OFS_CTRL) begin
			wr_ctrl = 1'b1;
		end
	end

	assign wr_accum_any = wr_accum_low || wr_accum_high || wr_accum_upr;

	// the low-byte write arms the shadow load
	assign link.low_write  = wr_step_low;
	assign link.step_value = step_q;

	// control: enable bit steers the accumulator
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			enable_q <= ENABLE_RESET;
		end else if (wr_ctrl) begin
			enable_q <= wdata_in[CTRL_ENABLE];
		end
	end

	// step bytes, each written on its own; no cross-byte latching
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			step_q <= STEP_RESET;
		end else if (wr_step_low) begin
			step_q[LOW_LSB +: DATA_W] <= wdata_in;
		end else if (wr_step_high) begin
			step_q[HIGH_LSB +: DATA_W] <= wdata_in;
		end else if (wr_step_upr) begin
			step_q[UPPER_LSB +: UPPER_W] <= wdata_in[UPPER_W-1:0];
		end
	end

	// accumulator: software write wins over the edge; result while running is undefined anyway
	assign advance = enable_q && link.rise;
	assign sum     = {1'b0, accum_q} + {1'b0, link.shadow};

	always_comb begin
		accum_d = accum_q;
		if (wr_accum_low) begin
			accum_d[LOW_LSB +: DATA_W] = wdata_in;
		end else if (wr_accum_high) begin
			accum_d[HIGH_LSB +: DATA_W] = wdata_in;
		end else if (wr_accum_upr) begin
			accum_d[UPPER_LSB +: UPPER_W] = wdata_in[UPPER_W-1:0];
		end else if (advance) begin
			accum_d = sum[PHASE_W-1:0];
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			accum_q <= ACCUM_RESET;
		end else begin
			accum_q <= accum_d;
		end
	end

	// carry out of bit 19 marks one full cycle of the phase
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			wrap_q <= 1'b0;
		end else begin
			wrap_q <= advance && !wr_accum_any && sum[PHASE_W];
		end
	end

	// read mux: data stand one cycle after the strobe and read zero otherwise
	always_comb begin
		rdata_d = RDATA_IDLE;
		if (!rd_in) begin
			rdata_d = RDATA_IDLE;
		end else if (addr_in == OFS_ACCUM_LOW) begin
			rdata_d = lane_of(accum_q, 2'h0);
		end else if (addr_in == OFS_ACCUM_HIGH) begin
			rdata_d = lane_of(accum_q, 2'h1);
		end else if (addr_in == OFS_ACCUM_UPR) begin
			rdata_d = lane_of(accum_q, 2'h2);
		end else if (addr_in == OFS_STEP_LOW) begin
			rdata_d = lane_of(step_q, 2'h0);
		end else if (addr_in == OFS_STEP_HIGH) begin
			rdata_d = lane_of(step_q, 2'h1);
		end else if (addr_in == OFS_STEP_UPR) begin
			rdata_d = lane_of(step_q, 2'h2);
		end else if (addr_in == OFS_CTRL) begin
			rdata_d[CTRL_ENABLE]  = enable_q;
			rdata_d[CTRL_PENDING] = link.pending;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_q <= RDATA_IDLE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata_out             = rdata_q;
	assign phase_accum_out       = accum_q;
	assign phase_step_shadow_out = link.shadow;
	assign accum_wrap_out        = wrap_q;
	assign osc_enable_out        = enable_q;

	// checks
	AST_RESET_VALUES: assert property (@(posedge clock_in)
		$fell(rst_in)
		|-> (accum_q == ACCUM_RESET && step_q == STEP_RESET && link.shadow == STEP_RESET))
		else $error("reset values wrong");

	AST_RESET_CTRL: assert property (@(posedge clock_in)
		$fell(rst_in)
		|-> (!link.pending && !enable_q && !accum_wrap_out && rdata_out == RDATA_IDLE))
		else $error("control state after reset wrong");

	AST_ACCUM_LOW_WRITE: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_in && addr_in == OFS_ACCUM_LOW)
		|=> (accum_q[7:0] == $past(wdata_in)))
		else $error("accumulator low byte not written");

	AST_ACCUM_LOW_READ: assert property (@(posedge clock_in) disable iff (rst_in)
		(rd_in && addr_in == OFS_ACCUM_LOW)
		|=> (rdata_out == $past(accum_q[LOW_LSB +: DATA_W])))
		else $error("accumulator low byte read wrong");

	AST_ACCUM_HIGH_WRITE: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_in && addr_in == OFS_ACCUM_HIGH)
		|=> (accum_q[HIGH_LSB +: DATA_W] == $past(wdata_in)))
		else $error("accumulator high byte not written");

	AST_ACCUM_HIGH_READ: assert property (@(posedge clock_in) disable iff (rst_in)
		(rd_in && addr_in == OFS_ACCUM_HIGH)
		|=> (rdata_out == $past(accum_q[15:8])))
		else $error("accumulator high byte read wrong");

	AST_ACCUM_UPPER_WRITE: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_in && addr_in == OFS_ACCUM_UPR)
		|=> (accum_q[UPPER_LSB +: UPPER_W] == $past(wdata_in[UPPER_W-1:0])))
		else $error("accumulator upper bits not written");

	AST_ACCUM_UPPER_READ: assert property (@(posedge clock_in) disable iff (rst_in)
		(rd_in && addr_in == OFS_ACCUM_UPR)
		|=> (rdata_out == {4'h0, $past(accum_q[19:16])}))
		else $error("accumulator upper byte read wrong");

	AST_ACCUM_SPACE: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_in && addr_in == OFS_ACCUM_UPR) ##1 (rd_in && addr_in == OFS_ACCUM_UPR && !link.rise)
		|=> (rdata_out[3:0] == $past(wdata_in[3:0], 2) && rdata_out[7:4] == 4'h0))
		else $error("upper accumulator bits not kept");

	AST_ACCUM_STEP: assert property (@(posedge clock_in) disable iff (rst_in)
		(enable_q && link.rise && !wr_accum_any)
		|=> (accum_q == PHASE_W'($past(accum_q) + $past(link.shadow))))
		else $error("accumulator did not add step");

	AST_ACCUM_IDLE: assert property (@(posedge clock_in) disable iff (rst_in)
		(!link.rise && !wr_accum_any)
		|=> $stable(accum_q))
		else $error("accumulator moved without input edge");

	AST_ACCUM_DISABLED: assert property (@(posedge clock_in) disable iff (rst_in)
		(!enable_q && !wr_accum_any)
		|=> $stable(accum_q))
		else $error("accumulator moved while disabled");

	// a modular add carries exactly when the result drops below the old value
	AST_WRAP_FLAG: assert property (@(posedge clock_in) disable iff (rst_in)
		(enable_q && link.rise && !wr_accum_any)
		|=> (accum_wrap_out == (accum_q < $past(accum_q))))
		else $error("wrap pulse does not match carry");

	AST_WRAP_ONLY_ADD: assert property (@(posedge clock_in) disable iff (rst_in)
		!(enable_q && link.rise && !wr_accum_any)
		|=> !accum_wrap_out)
		else $error("wrap pulse without an add");

	AST_ENABLE_WRITE: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_in && addr_in == OFS_CTRL)
		|=> (osc_enable_out == $past(wdata_in[CTRL_ENABLE])))
		else $error("enable bit not written");

	AST_ENABLE_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
		!(wr_in && addr_in == OFS_CTRL)
		|=> $stable(osc_enable_out))
		else $error("enable bit moved without write");

	AST_STEP_LOW_WRITE: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_in && addr_in == OFS_STEP_LOW)
		|=> (step_q[LOW_LSB +: DATA_W] == $past(wdata_in)) && $stable(step_q[PHASE_W-1:HIGH_LSB]))
		else $error("step low byte write wrong");

	AST_STEP_LOW_READ: assert property (@(posedge clock_in) disable iff (rst_in)
		(rd_in && addr_in == OFS_STEP_LOW)
		|=> (rdata_out == $past(step_q[LOW_LSB +: DATA_W])))
		else $error("step low byte read wrong");

	AST_STEP_HIGH: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_in && addr_in == OFS_STEP_HIGH)
		|=> (step_q[15:8] == $past(wdata_in)) && $stable(step_q[7:0]))
		else $error("step high byte write wrong");

	AST_STEP_HIGH_READ: assert property (@(posedge clock_in) disable iff (rst_in)
		(rd_in && addr_in == OFS_STEP_HIGH)
		|=> (rdata_out == $past(step_q[HIGH_LSB +: DATA_W])))
		else $error("step high byte read wrong");

	AST_STEP_UPPER_WRITE: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_in && addr_in == OFS_STEP_UPR)
		|=> (step_q[UPPER_LSB +: UPPER_W] == $past(wdata_in[UPPER_W-1:0])) && $stable(step_q[UPPER_LSB-1:0]))
		else $error("step upper bits write wrong");

	AST_STEP_UPPER: assert property (@(posedge clock_in) disable iff (rst_in)
		(rd_in && addr_in == OFS_STEP_UPR)
		|=> (rdata_out == {4'h0, $past(step_q[19:16])}))
		else $error("step upper byte read wrong");

	AST_STEP_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
		!(wr_in && (addr_in == OFS_STEP_LOW || addr_in == OFS_STEP_HIGH || addr_in == OFS_STEP_UPR))
		|=> $stable(step_q))
		else $error("step moved without write");

	AST_SHADOW_OUT_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
		!link.fall
		|=> $stable(phase_step_shadow_out))
		else $error("shadow output moved without falling edge");

	AST_CTRL_READ: assert property (@(posedge clock_in) disable iff (rst_in)
		(rd_in && addr_in == OFS_CTRL)
		|=> (rdata_out == {6'h00, $past(link.pending), $past(enable_q)}))
		else $error("control read wrong");

	AST_BYTE_INDEPENDENT: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_in && addr_in == OFS_ACCUM_HIGH && !link.rise)
		|=> $stable(accum_q[7:0]) && $stable(accum_q[19:16]))
		else $error("byte write disturbed other bytes");

	AST_ACCUM_LOW_KEEP: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_in && addr_in == OFS_ACCUM_LOW && !link.rise)
		|=> $stable(accum_q[PHASE_W-1:HIGH_LSB]))
		else $error("low byte write disturbed other bytes");

	AST_ACCUM_UPPER_KEEP: assert property (@(posedge clock_in) disable iff (rst_in)
		(wr_in && addr_in == OFS_ACCUM_UPR && !link.rise)
		|=> $stable(accum_q[UPPER_LSB-1:0]))
		else $error("upper write disturbed other bytes");

	AST_READ_ONE_CYCLE: assert property (@(posedge clock_in) disable iff (rst_in)
		!rd_in
		|=> (rdata_out == RDATA_IDLE))
		else $error("read data outside answer cycle");

endmodule : nco_phase_accumulator_regs
`default_nettype wire

// *** osc_source_model.sv ***
// clock source standing behind the oscillator input pin
// assumes the bench clock; whole periods only, held low while stopped
`timescale 1ns/1ps
`default_nettype none
module osc_source_model #(
	parameter int HALF = 6
) (
	input  wire logic clock_in,
	input  wire logic run_in,
	output var  logic osc_clk_out,
	output var  logic busy_out,
	output var  int   n_rise_out
);
	// a period is never cut short, so the pin never shows a runt phase
	initial begin
		osc_clk_out = 1'b0;
		busy_out    = 1'b0;
		n_rise_out  = 0;
		forever begin
			@(posedge clock_in);
			if (run_in) begin
				busy_out    <= 1'b1;
				osc_clk_out <= 1'b1;
				n_rise_out  <= n_rise_out + 1;
				repeat (HALF) @(posedge clock_in);
				osc_clk_out <= 1'b0;
				repeat (HALF) @(posedge clock_in);
			end else begin
				busy_out <= 1'b0;
			end
		end
	end
endmodule : osc_source_model
`default_nettype wire

// *** nco_phase_accumulator_regs_test.sv ***
// self-checking bench for the oscillator register block
// assumes package, link interface and design modules compiled first
`timescale 1ns/1ps
`default_nettype none
module nco_phase_accumulator_regs_test;
	import nco_pkg::*;
	logic               clock_in = 1'b0;
	logic               rst_in   = 1'b1;
	logic [ADDR_W-1:0]  addr_in  = '0;
	logic [DATA_W-1:0]  wdata_in = '0;
	logic               wr_in    = 1'b0;
	logic               rd_in    = 1'b0;
	logic               run      = 1'b0;
	logic               osc_clk;
	logic               osc_busy;
	int                 n_rise;
	logic [DATA_W-1:0]  rdata_out;
	logic [PHASE_W-1:0] phase_accum_out;
	logic [PHASE_W-1:0] phase_step_shadow_out;
	logic               accum_wrap_out;
	logic               osc_enable_out;
	int                 n_mismatch = 0;
	int                 checks     = 0;
	int                 n_wrap     = 0;
	int                 w;

	always #12.5 clock_in = ~clock_in;
	always @(posedge clock_in) if (accum_wrap_out === 1'b1) n_wrap <= n_wrap + 1;

	osc_source_model i_osc (.clock_in(clock_in), .run_in(run), .osc_clk_out(osc_clk),
		.busy_out(osc_busy), .n_rise_out(n_rise));
	nco_phase_accumulator_regs i_dut (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .osc_clk_in(osc_clk),
		.rdata_out(rdata_out), .phase_accum_out(phase_accum_out),
		.phase_step_shadow_out(phase_step_shadow_out), .accum_wrap_out(accum_wrap_out),
		.osc_enable_out(osc_enable_out));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict

	task automatic chk8(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk8

	task automatic chk20(input logic [PHASE_W-1:0] got, input logic [PHASE_W-1:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk20

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clock_in);
		wr_in    <= 1'b0;
	endtask : wr

	// read data is looked at only in the cycle after the strobe
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
		@(posedge clock_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clock_in);
		rd_in   <= 1'b0;
		#1;
		chk8(rdata_out, exp, what);
	endtask : rd_chk

	// whole source periods, then room for the three-stage synchroniser
	task automatic osc_periods(input int k);
		int target;
		int n;
		@(posedge clock_in);
		target = n_rise + k;
		run <= 1'b1;
		n = 0;
		while (n_rise < target && n < 2000) begin
			@(posedge clock_in);
			n++;
		end
		run <= 1'b0;
		do begin
			@(posedge clock_in);
			n++;
		end while (osc_busy === 1'b1 && n < 2000);
		if (n >= 2000) begin
			n_mismatch++;
			$display("wrong value at %0t: source clock hung", $time);
			print_verdict();
		end
		repeat (6) @(posedge clock_in);
	endtask : osc_periods

	task automatic test_reset();
		chk20(phase_accum_out, 20'h00000, "accum out");
		chk20(phase_step_shadow_out, 20'h00001, "shadow out");
		rd_chk(OFS_ACCUM_LOW, 8'h00, "accum low");
		rd_chk(OFS_ACCUM_HIGH, 8'h00, "accum high");
		rd_chk(OFS_ACCUM_UPR, 8'h00, "accum upper");
		rd_chk(OFS_STEP_LOW, 8'h01, "step low");
		rd_chk(OFS_STEP_HIGH, 8'h00, "step high");
		rd_chk(OFS_STEP_UPR, 8'h00, "step upper");
		rd_chk(3'h7, 8'h00, "unmapped");
		@(posedge clock_in);
		#1;
		chk8(rdata_out, 8'h00, "idle rdata");
		$display("test reset done");
	endtask : test_reset

	task automatic test_regs();
		wr(OFS_ACCUM_LOW, 8'hff);
		wr(OFS_ACCUM_HIGH, 8'hff);
		wr(OFS_ACCUM_UPR, 8'hff);
		wr(3'h7, 8'h5a);
		rd_chk(OFS_ACCUM_LOW, 8'hff, "accum low");
		rd_chk(OFS_ACCUM_HIGH, 8'hff, "accum high");
		rd_chk(OFS_ACCUM_UPR, 8'h0f, "accum upper");
		rd_chk(3'h7, 8'h00, "unmapped");
		chk20(phase_accum_out, 20'hfffff, "accum out");
		wr(OFS_STEP_UPR, 8'hff);
		wr(OFS_STEP_HIGH, 8'ha5);
		wr(OFS_STEP_LOW, 8'h3c);
		rd_chk(OFS_STEP_UPR, 8'h0f, "step upper");
		rd_chk(OFS_STEP_HIGH, 8'ha5, "step high");
		rd_chk(OFS_STEP_LOW, 8'h3c, "step low");
		rd_chk(OFS_CTRL, 8'h02, "pending set");
		chk20(phase_step_shadow_out, 20'h00001, "shadow before fall");
		$display("test regs done");
	endtask : test_regs

	// one period with the oscillator disabled: the fall loads, the rise adds nothing
	task automatic test_shadow();
		osc_periods(1);
		chk20(phase_step_shadow_out, 20'hfa53c, "shadow after fall");
		chk20(phase_accum_out, 20'hfffff, "accum while disabled");
		rd_chk(OFS_CTRL, 8'h00, "pending clear");
		$display("test shadow done");
	endtask : test_shadow

	task automatic test_accum();
		wr(OFS_STEP_UPR, 8'h00);
		wr(OFS_STEP_HIGH, 8'h00);
		wr(OFS_STEP_LOW, 8'h20);
		osc_periods(1);
		chk20(phase_step_shadow_out, 20'h00020, "shadow step");
		wr(OFS_ACCUM_LOW, 8'hf0);
		wr(OFS_CTRL, 8'h01);
		@(posedge clock_in);
		#1;
		chk8({7'h00, osc_enable_out}, 8'h01, "enable out");
		w = n_wrap;
		osc_periods(3);
		chk20(phase_accum_out, 20'h00050, "accum after adds");
		chk8(8'(n_wrap - w), 8'h01, "wrap pulses");
		rd_chk(OFS_ACCUM_LOW, 8'h50, "accum low");
		rd_chk(OFS_ACCUM_HIGH, 8'h00, "accum high");
		rd_chk(OFS_ACCUM_UPR, 8'h00, "accum upper");
		wr(OFS_CTRL, 8'h00);
		osc_periods(2);
		chk20(phase_accum_out, 20'h00050, "accum disabled");
		$display("test accum done");
	endtask : test_accum

	// write, read, read with no idle cycle between the strobes
	task automatic test_back_to_back();
		@(posedge clock_in);
		addr_in  <= OFS_ACCUM_UPR;
		wdata_in <= 8'hf5;
		wr_in    <= 1'b1;
		@(posedge clock_in);
		wr_in    <= 1'b0;
		rd_in    <= 1'b1;
		@(posedge clock_in);
		addr_in  <= OFS_STEP_LOW;
		#1;
		chk8(rdata_out, 8'h05, "b2b accum upper");
		@(posedge clock_in);
		rd_in    <= 1'b0;
		#1;
		chk8(rdata_out, 8'h20, "b2b step low");
		chk20(phase_accum_out, 20'h50050, "b2b accum out");
		$display("test back to back done");
	endtask : test_back_to_back

	// reset in mid-run clears what software wrote and the armed shadow load
	task automatic test_mid_reset();
		wr(OFS_STEP_LOW, 8'h77);
		wr(OFS_CTRL, 8'h01);
		@(posedge clock_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		rst_in <= 1'b0;
		chk20(phase_accum_out, 20'h00000, "accum after reset");
		chk20(phase_step_shadow_out, 20'h00001, "shadow after reset");
		chk8({7'h00, osc_enable_out}, 8'h00, "enable after reset");
		rd_chk(OFS_STEP_LOW, 8'h01, "step low after reset");
		rd_chk(OFS_CTRL, 8'h00, "ctrl after reset");
		$display("test mid reset done");
	endtask : test_mid_reset

	initial begin
		repeat (8) @(posedge clock_in);
		rst_in <= 1'b0;
		test_reset();
		test_regs();
		test_shadow();
		test_accum();
		test_back_to_back();
		test_mid_reset();
		print_verdict();
	end
endmodule : nco_phase_accumulator_regs_test
`default_nettype wire
